// ==== verilog/scl_loader.sv ====
// Configuration loader of a RAM based logic array: five load modes and daisy chain.
// Assumes config_clock is also wired as the link clock port; all pins are asynchronous.
module scl_loader
  import scl_pkg::*;
#(
  parameter int OWN_BYTES = OWN_BYTES_SMALL,
  parameter bit LSB_FIRST = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        reset_pin_n,
  input  wire logic        mode_pin_zero,
  input  wire logic        mode_pin_one,
  output logic             mode_pin_one_out,
  output logic             mode_pin_one_oe,
  input  wire logic        mode_pin_two,
  input  wire logic        config_clock,
  output logic             config_clock_out,
  output logic             config_clock_oe,
  input  wire logic [7:0]  data_pins,
  output logic             dout,
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe,
  output logic             high_while_loading,
  output logic             high_while_loading_oe,
  output logic             low_while_loading,
  output logic             low_while_loading_oe,
  output logic [15:0]      address,
  output logic             address_oe,
  output logic             read_clock,
  input  wire logic        host_write_strobe_n,
  input  wire logic        select_first_n,
  input  wire logic        select_second_n,
  input  wire logic        select_third,
  output logic [7:0]       config_data,
  output logic             config_valid,
  output logic             user_active,
  output logic             user_clear,
  input  wire logic        readback_bit,
  output logic             readback_next
);

  localparam logic [15:0] OWN_BITS = 16'(OWN_BYTES * BYTE_BITS);
  localparam logic [3:0]  HALF_CYC = 4'(CONFIG_CLOCK_HALF_CYC);
  localparam logic [3:0]  WAIT_CYC = 4'(RD_WAIT_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 18;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic            rstn_s;
  logic            m0_s;
  logic            m1_s;
  logic            m2_s;
  logic            wr_s;
  logic            cs0_s;
  logic            cs1_s;
  logic            cs2_s;
  logic            done_s;
  logic            config_clock_s;
  logic [7:0]      data_s;
  logic            din_s;

  always_ff @(posedge mclk) begin
    pin_s1 <= {reset_pin_n, mode_pin_zero, mode_pin_one, mode_pin_two, host_write_strobe_n,
               select_first_n, select_second_n, select_third, done_in, config_clock, data_pins};
    pin_s2 <= pin_s1;
  end

  assign {rstn_s, m0_s, m1_s, m2_s, wr_s, cs0_s, cs1_s, cs2_s, done_s, config_clock_s, data_s} = pin_s2;
  assign din_s = data_s[0];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  logic rstn_d;
  logic wr_d;
  logic done_d;
  logic config_clock_d;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_d;

  scl_link_if lk ();

  always_ff @(posedge mclk) begin
    if (reset) begin
      rstn_d <= 1'b1;
      wr_d   <= 1'b1;
      done_d <= 1'b0;
      config_clock_d <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_d  <= 1'b0;
    end else begin
      rstn_d <= rstn_s;
      wr_d   <= wr_s;
      done_d <= done_s;
      config_clock_d <= config_clock_s;
      tgl_s1 <= lk.byte_tgl;
      tgl_s2 <= tgl_s1;
      tgl_d  <= tgl_s2;
    end
  end

  logic rstn_rise;
  logic done_fall;
  logic slave_byte;
  logic write_evt;

  assign rstn_rise  = rstn_s & ~rstn_d;
  assign done_fall  = ~done_s & done_d;
  assign slave_byte = tgl_s2 ^ tgl_d;
  // Selects must stand valid when the strobe falls
  assign write_evt  = ~wr_s & wr_d & ~cs0_s & ~cs1_s & cs2_s;

  // ----------------------------------------------------------------
  // Main state machine
  // ----------------------------------------------------------------
  scl_state_t state;
  scl_mode_t  mode;
  logic       own_done;
  logic       load_start;
  logic       loading;
  logic       is_master;
  logic       is_parallel;

  assign load_start  = (state == ST_INIT && rstn_rise) || (state == ST_USER && done_fall);
  assign loading     = (state == ST_LOAD);
  assign is_parallel = (mode == MODE_MUP) || (mode == MODE_MDOWN);
  assign is_master   = is_parallel || (mode == MODE_MSER);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_INIT;
    end else begin
      unique case (state)
        ST_INIT: begin
          if (rstn_rise) state <= ST_LOAD;
        end
        ST_LOAD: begin
          if (!rstn_s) begin
            state <= ST_INIT;
          end else if (own_done && done_s) begin
            state <= ST_USER;
          end
        end
        ST_USER: begin
          if (!rstn_s) begin
            state <= ST_CLEAR;
          end else if (done_fall) begin
            state <= ST_LOAD;
          end
        end
        ST_CLEAR: begin
          if (rstn_s) state <= ST_USER;
        end
      endcase
    end
  end

  // Mode is only taken from the pins as the reset pin rises
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode <= MODE_SLAVE;
    end else if (state == ST_INIT && rstn_rise) begin
      mode <= decode_mode({m2_s, m1_s, m0_s});
    end
  end

  // ----------------------------------------------------------------
  // Configuration clock divider
  // ----------------------------------------------------------------
  logic [3:0] div_cnt;
  logic       pend;
  logic       config_clock_run;
  logic       tick_rise;
  logic       tick_fall;

  assign config_clock_run  = loading && (is_master || pend);
  assign tick_rise = (div_cnt == HALF_CYC - 4'h1) && !config_clock_out && config_clock_run;
  assign tick_fall = (div_cnt == HALF_CYC - 4'h1) && config_clock_out;

  always_ff @(posedge mclk) begin
    if (reset || load_start) begin
      div_cnt          <= '0;
      config_clock_out <= 1'b0;
    end else if (div_cnt == HALF_CYC - 4'h1) begin
      div_cnt <= '0;
      if (tick_rise || tick_fall) config_clock_out <= ~config_clock_out;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Master parallel fetch
  // ----------------------------------------------------------------
  scl_fetch_t fetch;
  logic [3:0] wait_cnt;
  logic [7:0] byte_sh;
  logic [2:0] bit_pos;
  logic       par_take;
  logic       par_bit;
  logic       start_down;

  assign par_take = loading && is_parallel && fetch == FS_SHIFT && tick_fall;
  assign par_bit  = LSB_FIRST ? byte_sh[0] : byte_sh[7];
  // Mode latches on the load edge itself, so a fresh load reads the pins
  assign start_down = (state == ST_INIT) ? decode_mode({m2_s, m1_s, m0_s}) == MODE_MDOWN : mode == MODE_MDOWN;

  always_ff @(posedge mclk) begin
    if (reset || load_start) begin
      fetch    <= FS_ADDR;
      wait_cnt <= '0;
      byte_sh  <= '0;
      bit_pos  <= '0;
      address  <= start_down ? ADDR_DOWN_START : ADDR_UP_START;
    end else if (loading && is_parallel) begin
      unique case (fetch)
        FS_ADDR: begin
          wait_cnt <= '0;
          fetch    <= FS_WAIT;
        end
        FS_WAIT: begin
          // Covers the memory access plus the pin synchroniser
          if (wait_cnt == WAIT_CYC - 4'h1) begin
            byte_sh <= data_s;
            bit_pos <= '0;
            fetch   <= FS_SHIFT;
          end else begin
            wait_cnt <= wait_cnt + 4'h1;
          end
        end
        FS_SHIFT: begin
          if (par_take) begin
            byte_sh <= LSB_FIRST ? {1'b0, byte_sh[7:1]} : {byte_sh[6:0], 1'b0};
            bit_pos <= bit_pos + 3'h1;
            if (bit_pos == 3'h7) begin
              address <= (mode == MODE_MDOWN) ? address - 16'h0001 : address + 16'h0001;
              fetch   <= FS_ADDR;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit source selection
  // ----------------------------------------------------------------
  logic bit_take;
  logic bit_val;

  always_comb begin
    bit_take = 1'b0;
    bit_val  = 1'b0;
    if (loading) begin
      unique case (mode)
        MODE_MSER: begin
          bit_take = tick_fall;
          bit_val  = din_s;
        end
        MODE_MUP, MODE_MDOWN: begin
          bit_take = par_take;
          bit_val  = par_bit;
        end
        MODE_PERIPH: begin
          bit_take = write_evt;
          bit_val  = din_s;
        end
        MODE_SLAVE: begin
          bit_take = 1'b0;
          bit_val  = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Own image counting and forwarding
  // ----------------------------------------------------------------
  logic [15:0] bit_cnt;
  logic [7:0]  asm_byte;
  logic        fwd_bit;

  always_ff @(posedge mclk) begin
    if (reset || load_start) begin
      bit_cnt      <= '0;
      asm_byte     <= '0;
      own_done     <= 1'b0;
      config_valid <= 1'b0;
      config_data  <= '0;
      fwd_bit      <= 1'b1;
    end else begin
      config_valid <= 1'b0;
      if (loading && mode == MODE_SLAVE && slave_byte && !own_done) begin
        config_data  <= lk.byte_data;
        config_valid <= 1'b1;
        bit_cnt      <= bit_cnt + 16'(BYTE_BITS);
        if (bit_cnt + 16'(BYTE_BITS) == OWN_BITS) own_done <= 1'b1;
      end else if (bit_take && !own_done) begin
        asm_byte <= {asm_byte[6:0], bit_val};
        bit_cnt  <= bit_cnt + 16'h0001;
        if (bit_cnt[2:0] == 3'h7) begin
          config_data  <= {asm_byte[6:0], bit_val};
          config_valid <= 1'b1;
        end
        if (bit_cnt == OWN_BITS - 16'h0001) own_done <= 1'b1;
      end else if (bit_take) begin
        // Set a half period ahead of the rising edge the link samples on in the master modes, 1 to 4 mclk cycles ahead in peripheral mode
        fwd_bit <= bit_val;
      end
    end
  end

  // Peripheral mode clocks one forwarded bit per host write
  always_ff @(posedge mclk) begin
    if (reset || load_start) begin
      pend <= 1'b0;
    end else if (mode == MODE_PERIPH && bit_take && own_done) begin
      pend <= 1'b1;
    end else if (tick_rise) begin
      pend <= 1'b0;
    end
  end

  assign lk.slave_en = loading && mode == MODE_SLAVE;
  assign lk.fwd_bit  = fwd_bit;

  scl_link_rx #(
    .OWN_BYTES (OWN_BYTES)
  ) u_link (
    .link_clk (config_clock),
    .reset    (reset),
    .din      (data_pins[0]),
    .dout     (dout),
    .lk       (lk)
  );

  // ----------------------------------------------------------------
  // Pin drivers during and after loading
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_out              <= 1'b0;
      done_oe               <= 1'b1;
      config_clock_oe       <= 1'b0;
      address_oe            <= 1'b0;
      read_clock            <= 1'b1;
      high_while_loading    <= 1'b1;
      high_while_loading_oe <= 1'b1;
      low_while_loading     <= 1'b0;
      low_while_loading_oe  <= 1'b1;
      user_active           <= 1'b0;
      user_clear            <= 1'b0;
    end else begin
      done_out              <= 1'b0;
      done_oe               <= (state == ST_INIT) || (loading && !own_done);
      config_clock_oe       <= loading && mode != MODE_SLAVE;
      address_oe            <= loading && is_parallel;
      high_while_loading    <= 1'b1;
      high_while_loading_oe <= (state == ST_INIT) || loading;
      low_while_loading     <= 1'b0;
      low_while_loading_oe  <= (state == ST_INIT) || loading;
      user_active           <= (state == ST_USER);
      user_clear            <= (state == ST_CLEAR);
      if (loading && is_parallel) begin
        read_clock <= (fetch == FS_SHIFT);
      end else if (loading && mode == MODE_MSER) begin
        // PROM advances on the high phase; stops once done releases
        read_clock <= config_clock_out && !done_s;
      end else begin
        read_clock <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback in user operation
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_pin_one_out <= 1'b0;
      mode_pin_one_oe  <= 1'b0;
      readback_next    <= 1'b0;
    end else begin
      mode_pin_one_oe <= (state == ST_USER);
      readback_next   <= 1'b0;
      if (state == ST_USER && m0_s && config_clock_s && !config_clock_d) begin
        mode_pin_one_out <= readback_bit;
        readback_next    <= 1'b1;
      end
    end
  end

endmodule

// ==== verilog/scl_pkg.sv ====
// Shared constants, types and helpers of the serial array configuration loader.
// Assumes one mclk domain of 25 MHz plus the config_clock domain at the link.
package scl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS  = 40;
  localparam int CONFIG_CLOCK_HALF_NS    = 160;
  localparam int EPROM_ACCESS_NS = 120;
  localparam int SYNC_STAGES     = 2;
  // Least times round up to whole mclk cycles
  localparam int CONFIG_CLOCK_HALF_CYC   = (CONFIG_CLOCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int RD_WAIT_CYC     = (EPROM_ACCESS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS + SYNC_STAGES;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          OWN_BYTES_SMALL = 1505;
  localparam int          OWN_BYTES_LARGE = 2235;
  localparam int          BYTE_BITS       = 8;
  localparam logic [15:0] ADDR_UP_START   = 16'h0000;
  localparam logic [15:0] ADDR_DOWN_START = 16'hFFFF;

  // ----------------------------------------------------------------
  // Mode codes, packed as {mode_pin_two, mode_pin_one, mode_pin_zero}
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] CODE_MASTER_UP     = 3'h4;
  localparam logic [2:0] CODE_MASTER_DOWN   = 3'h6;
  localparam logic [2:0] CODE_PERIPHERAL    = 3'h5;
  localparam logic [2:0] CODE_SLAVE         = 3'h7;

  typedef enum logic [2:0] {MODE_MSER, MODE_MUP, MODE_MDOWN, MODE_PERIPH, MODE_SLAVE} scl_mode_t;
  typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_USER, ST_CLEAR} scl_state_t;
  typedef enum logic [1:0] {FS_ADDR, FS_WAIT, FS_SHIFT} scl_fetch_t;

  // Undefined codes fall back to slave, where the device drives neither config_clock nor the address bus
  function automatic scl_mode_t decode_mode(input logic [2:0] code);
    scl_mode_t m;
    m = MODE_SLAVE;
    unique case (code)
      CODE_MASTER_SERIAL: m = MODE_MSER;
      CODE_MASTER_UP:     m = MODE_MUP;
      CODE_MASTER_DOWN:   m = MODE_MDOWN;
      CODE_PERIPHERAL:    m = MODE_PERIPH;
      default:            m = MODE_SLAVE;
    endcase
    return m;
  endfunction

endpackage

// ==== verilog/scl_link_if.sv ====
// Carrier between the mclk core and the config_clock side shifter.
// Assumes slave_en and fwd_bit are levels; byte_tgl flips once per byte.
interface scl_link_if;
  logic       slave_en;
  logic       fwd_bit;
  logic       byte_tgl;
  logic [7:0] byte_data;

  modport core (
    output slave_en,
    output fwd_bit,
    input  byte_tgl,
    input  byte_data
  );

  modport link (
    input  slave_en,
    input  fwd_bit,
    output byte_tgl,
    output byte_data
  );
endinterface

// ==== verilog/scl_link_rx.sv ====
// Link side of the loader, clocked by the config_clock pin.
// Assumes the core holds fwd_bit steady across each config_clock rising edge.
module scl_link_rx
  import scl_pkg::*;
#(
  parameter int OWN_BYTES = OWN_BYTES_SMALL
) (
  input  wire logic link_clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout,
  scl_link_if.link  lk
);

  // ----------------------------------------------------------------
  // Level crossings into the link domain
  // ----------------------------------------------------------------
  logic       rst_s1;
  logic       rst_s2;
  logic       en_s1;
  logic       en_s2;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic [15:0] byte_cnt;
  logic       own_full;

  always_ff @(posedge link_clk) begin
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
    en_s1  <= lk.slave_en;
    en_s2  <= en_s1;
  end

  assign own_full = (byte_cnt == 16'(OWN_BYTES));

  // ----------------------------------------------------------------
  // Serial capture, first bit lands in the byte's top bit
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (rst_s2 || !en_s2) begin
      bit_idx  <= '0;
      shreg    <= '0;
      byte_cnt <= '0;
    end else if (!own_full) begin
      shreg   <= {shreg[6:0], din};
      bit_idx <= bit_idx + 3'h1;
      if (bit_idx == 3'h7) begin
        byte_cnt <= byte_cnt + 16'h0001;
      end
    end
  end

  // Data held for a whole byte time while the core picks it up
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      lk.byte_tgl  <= 1'b0;
      lk.byte_data <= '0;
    end else if (en_s2 && !own_full && bit_idx == 3'h7) begin
      lk.byte_data <= {shreg[6:0], din};
      lk.byte_tgl  <= ~lk.byte_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Daisy chain output
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      dout <= 1'b1;
    end else if (en_s2) begin
      dout <= own_full ? din : 1'b1;
    end else begin
      dout <= lk.fwd_bit;
    end
  end

endmodule

// ==== bench/scl_checker.sv ====
// Pin checker of scl_loader, bound to every instance.
// Assumes the done line is resolved with a pull-up.
module scl_checker (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        reset_pin_n,
  input wire logic        mode_pin_zero,
  input wire logic        mode_pin_one,
  input wire logic        mode_pin_two,
  input wire logic        mode_pin_one_oe,
  input wire logic        config_clock_oe,
  input wire logic        done_in,
  input wire logic        done_out,
  input wire logic        done_oe,
  input wire logic        high_while_loading,
  input wire logic        high_while_loading_oe,
  input wire logic        low_while_loading,
  input wire logic [15:0] address,
  input wire logic        address_oe,
  input wire logic        config_valid,
  input wire logic        user_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rstn_q;
  logic slave_q;
  // Mode code as latched by a reset pin rise outside user operation
  always_ff @(posedge mclk) begin
    rstn_q <= reset_pin_n;
    if (reset) slave_q <= 1'b0;
    else if (reset_pin_n && !rstn_q && high_while_loading_oe)
      slave_q <= {mode_pin_two, mode_pin_one, mode_pin_zero} == 3'h7;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  flags_level_a: assert property (high_while_loading_oe |-> high_while_loading && !low_while_loading)
    else $error("loading flags wrong");
  clk_dir_a: assert property (high_while_loading_oe && slave_q |-> !config_clock_oe)
    else $error("clock driven in slave");
  done_wired_a: assert property (!done_out) else $error("done driven high");
  done_free_a: assert property (user_active |-> !done_oe) else $error("done held in user");
  start_sync_a: assert property ($rose(user_active) |-> $past(done_in, 2))
    else $error("user start without done");
  user_hold_a: assert property (!done_in [*8] |-> !user_active) else $error("user while done low");
  addr_start_a: assert property ($rose(address_oe) |-> address == 16'h0000 || address == 16'hFFFF)
    else $error("bad first address");
  addr_step_a: assert property (address_oe && $past(address_oe) && address != $past(address)
    |-> address == $past(address) + 16'h0001 || address == $past(address) - 16'h0001) else $error("address jump");
  valid_pulse_a: assert property (config_valid |=> !config_valid) else $error("valid too long");
  rb_user_a: assert property (mode_pin_one_oe |-> user_active) else $error("readback out in load");

  user_c: cover property ($rose(user_active));
  down_c: cover property ($rose(address_oe) && address == 16'hFFFF);
  byte_c: cover property (config_valid);
endmodule

bind scl_loader scl_checker scl_checker_i (.mclk, .reset, .reset_pin_n, .mode_pin_zero, .mode_pin_one, .mode_pin_two,
  .mode_pin_one_oe, .config_clock_oe, .done_in, .done_out, .done_oe, .high_while_loading,
  .high_while_loading_oe, .low_while_loading, .address, .address_oe, .config_valid, .user_active);

// ==== bench/scl_eprom.sv ====
// Byte wide configuration memory on the buses, plus a serial PROM on read_clock.
// Assumes read_clock low with address_oe high enables its outputs.
module scl_eprom (
  input  wire logic [15:0] address,
  input  wire logic        read_clock,
  input  wire logic        address_oe,
  input  wire logic        ser_rst,
  output logic      [7:0]  data,
  output logic             ser_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Released bus shows inverse data, never a stale byte
  assign data = (address_oe && !read_clock) ? pat(address) : ~pat(address);
  // Serial PROM: each read_clock rise shifts out the next bit, top bit first
  function automatic logic sbit(input int unsigned k);
    logic [7:0] v;
    v = 8'hC3 ^ k[10:3];
    return v[3'h7 - k[2:0]];
  endfunction
  int unsigned n_bit;
  always @(posedge read_clock or posedge ser_rst) begin
    if (ser_rst) begin
      n_bit   <= 0;
      ser_bit <= 1'b1;
    end else begin
      ser_bit <= sbit(n_bit);
      n_bit   <= n_bit + 1;
    end
  end
endmodule

// ==== bench/scl_loader_tb_top.sv ====
// Self-checking bench of scl_loader: master up, master down, slave, peripheral, master serial.
// Assumes config_clock resolves from the loader's enable and the bench's link clock.
module scl_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int NB = 4;
  logic        mclk = 1'b0, reset = 1'b1, reset_pin_n = 1'b1;
  logic        mode_pin_zero = 1'b1, mode_pin_one = 1'b1, mode_pin_two = 1'b1;
  logic        host_write_strobe_n = 1'b1, select_first_n = 1'b1, select_second_n = 1'b1, select_third = 1'b0;
  logic        readback_bit = 1'b0, din_b = 1'b0, clk_b = 1'b1, pull = 1'b0, rom_en = 1'b0, ser_on = 1'b0;
  logic        mode_pin_one_out, mode_pin_one_oe, config_clock_out, config_clock_oe, dout, done_out, done_oe;
  logic        high_while_loading, high_while_loading_oe, low_while_loading, low_while_loading_oe;
  logic        address_oe, read_clock, config_valid, user_active, user_clear, readback_next, ser_bit;
  logic [15:0] address;
  logic [7:0]  config_data, rom_q;
  logic [7:0]  got [$];
  int          errors = 0, n_compared = 0;
  wire logic   config_clock, done_in;
  wire logic [7:0] data_pins;

  assign config_clock = config_clock_oe ? config_clock_out : clk_b;
  assign done_in = !(done_oe || pull);
  assign data_pins = rom_en ? rom_q : {7'h00, ser_on ? ser_bit : din_b};

  scl_loader #(.OWN_BYTES(NB)) scl_loader_i (.mclk, .reset, .reset_pin_n, .mode_pin_zero, .mode_pin_one,
    .mode_pin_one_out, .mode_pin_one_oe, .mode_pin_two, .config_clock, .config_clock_out, .config_clock_oe,
    .data_pins, .dout, .done_in, .done_out, .done_oe, .high_while_loading, .high_while_loading_oe,
    .low_while_loading, .low_while_loading_oe, .address, .address_oe, .read_clock, .host_write_strobe_n,
    .select_first_n, .select_second_n, .select_third, .config_data, .config_valid, .user_active, .user_clear,
    .readback_bit, .readback_next);
  scl_eprom scl_eprom_i (.address, .read_clock, .address_oe, .ser_rst(!ser_on), .data(rom_q), .ser_bit);

  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (config_valid === 1'b1) got.push_back(config_data);
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Done pulled low first, so a finished device reloads
  task automatic start(input logic [2:0] c, input logic r);
    {mode_pin_two, mode_pin_one, mode_pin_zero} = c;
    rom_en = r;
    pull = 1'b1;
    cyc(4);
    pull = 1'b0;
    reset_pin_n = 1'b0;
    cyc(4);
    reset_pin_n = 1'b1;
    cyc(8);
    got.delete();
    chk(high_while_loading_oe, 1);
  endtask
  task automatic wait_own();
    int k;
    k = 0;
    while (done_oe !== 1'b0 && k < 5000) begin
      cyc(1);
      k++;
    end
    chk(k < 5000, 1);
  endtask
  task automatic chk_bytes(input logic [7:0] b0);
    chk(got.size(), NB);
    foreach (got[i]) chk(got[i], b0 ^ i[7:0]);
  endtask
  // Link clock runs at 12 ns, one period per bit, then rests for ten mclk cycles
  task automatic sbyte(input logic [7:0] v, input bit fwd);
    for (int b = 7; b >= 0; b--) begin
      din_b = v[b];
      #3 clk_b = 1'b0;
      #6 clk_b = 1'b1;
      #3;
      if (fwd) chk(dout, v[b]);
    end
    cyc(10);
  endtask
  task automatic lpulse(input int n);
    repeat (n) begin
      #6 clk_b = 1'b0;
      #6 clk_b = 1'b1;
    end
  endtask
  task automatic pwr(input logic b, input logic s3);
    din_b = b;
    select_third = s3;
    select_first_n = 1'b0;
    select_second_n = 1'b0;
    host_write_strobe_n = 1'b0;
    cyc(6);
    host_write_strobe_n = 1'b1;
    cyc(6);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_up();
    start(scl_pkg::CODE_MASTER_UP, 1'b1);
    chk(address, 16'h0000);
    chk(config_clock_oe, 1);
    pull = 1'b1;
    wait_own();
    cyc(200);
    chk(address > 16'h0004, 1);
    chk(user_active, 0);
    pull = 1'b0;
    cyc(10);
    chk(user_active, 1);
    chk_bytes(8'h3C);
  endtask
  task automatic t_down();
    start(scl_pkg::CODE_MASTER_DOWN, 1'b1);
    chk(address, 16'hFFFF);
    wait_own();
    cyc(10);
    chk_bytes(8'h3C);
    chk(user_active, 1);
  endtask
  task automatic t_slave();
    start(scl_pkg::CODE_SLAVE, 1'b0);
    chk(config_clock_oe, 0);
    // Two edges carry the enable into the link side
    lpulse(2);
    pull = 1'b1;
    for (int i = 0; i < NB; i++) sbyte(8'hA0 ^ i[7:0], 1'b0);
    wait_own();
    sbyte(8'h5A, 1'b1);
    pull = 1'b0;
    cyc(10);
    chk_bytes(8'hA0);
    chk(user_active, 1);
    reset_pin_n = 1'b0;
    cyc(6);
    chk(user_clear, 1);
    chk(high_while_loading_oe, 0);
    reset_pin_n = 1'b1;
    cyc(6);
    chk(user_active, 1);
  endtask
  task automatic t_periph();
    logic [7:0] v;
    start(scl_pkg::CODE_PERIPHERAL, 1'b0);
    chk(config_clock_oe, 1);
    pwr(1'b1, 1'b0);
    for (int i = 0; i < NB; i++) begin
      v = 8'h69 ^ i[7:0];
      for (int b = 7; b >= 0; b--) pwr(v[b], 1'b1);
    end
    wait_own();
    cyc(10);
    chk_bytes(8'h69);
  endtask
  task automatic t_mser();
    ser_on = 1'b1;
    start(scl_pkg::CODE_MASTER_SERIAL, 1'b0);
    chk(config_clock_oe, 1);
    wait_own();
    cyc(10);
    chk_bytes(8'hC3);
    chk(user_active, 1);
    ser_on = 1'b0;
  endtask
  task automatic finish_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    cyc(2);
    // Link side only resets while its clock runs
    lpulse(4);
    cyc(3);
    reset = 1'b0;
    cyc(4);
    t_up();
    t_down();
    t_slave();
    t_periph();
    t_mser();
    finish_test();
  end
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
endmodule
